// ===== srst_pkg.sv
// Constants shared by the system reset controller files
package srst_pkg;

    // Reset request source positions in the request vector
    localparam int SRC_W     = 8;
    localparam int SRC_POR   = 0;
    localparam int SRC_PIN   = 1;
    localparam int SRC_CMP   = 2;
    localparam int SRC_SW    = 3;
    localparam int SRC_SMON  = 4;
    localparam int SRC_WDT   = 5;
    localparam int SRC_MCD   = 6;
    localparam int SRC_FLASH = 7;

    // Sources that come from other domains and need two flip-flops
    localparam logic [SRC_W-1:0] SYNC_MASK = 8'h77;

    // Timing
    localparam int CLK_PERIOD_PS   = 8000;
    localparam int RELEASE_TIME_NS = 64;
    localparam int RELEASE_CYCLES  =
        (RELEASE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int PIN_MASK_CYCLES = 4;
    localparam int CNT_W           = 8;

    // Exit conditions
    localparam int              ADDR_W      = 16;
    localparam logic [15:0]     START_VECTOR = 16'h0000;
    localparam logic            PORT_LATCH_RESET = 1'h1;

    // Values after reset of the request synchroniser and cause record
    localparam logic [SRC_W-1:0] SYNC_RESET  = 8'h00;
    localparam logic [SRC_W-1:0] CAUSE_RESET = 8'h01;

    typedef enum logic [1:0] {
        SRST_RUN,
        SRST_HOLD,
        SRST_RELEASE,
        SRST_EXIT
    } srst_state_t;

endpackage

// ===== srst_req_if.sv
// Carrier for the synchronised reset requests
`timescale 1ns/1ps
`default_nettype none
interface srst_req_if;
    logic [srst_pkg::SRC_W-1:0] req;

    modport src (output req);
    modport dst (input  req);
endinterface
`default_nettype wire

// ===== srst_sync.sv
// Two flip-flop synchroniser for the reset request inputs
`timescale 1ns/1ps
`default_nettype none
module srst_sync #(
    parameter logic [srst_pkg::SRC_W-1:0] MASK = srst_pkg::SYNC_MASK
) (
    input  wire logic                      clk,
    input  wire logic                      rst,
    input  wire logic [srst_pkg::SRC_W-1:0] raw,
    srst_req_if.src                        out
);
    logic [srst_pkg::SRC_W-1:0] meta;
    logic [srst_pkg::SRC_W-1:0] stable;
    logic [srst_pkg::SRC_W-1:0] next_meta;
    logic [srst_pkg::SRC_W-1:0] next_stable;

    always_comb begin
        next_meta   = raw;
        next_stable = meta;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            meta   <= srst_pkg::SYNC_RESET;
            stable <= srst_pkg::SYNC_RESET;
        end else begin
            meta   <= next_meta;
            stable <= next_stable;
        end
    end

    // Same-clock sources bypass the chain to save two cycles of latency
    always_comb begin
        for (int i = 0; i < srst_pkg::SRC_W; i++) begin
            out.req[i] = MASK[i] ? stable[i] : raw[i];
        end
    end
endmodule // srst_sync
`default_nettype wire

// ===== srst_ctrl.sv
// System reset controller: source merge, reset state and exit sequence
// Operation
// - Entering reset halts the core so no further instructions run.
// - Reset loads register defaults; power-on-only bits reset on POR.
// - In reset, port pins go to known state; interrupts, timers off.
// - Reset never alters RAM; writes are blocked while in reset.
// - Port latches default to 1, open-drain, weak pull-ups on.
// - Optional hold of ports, DACs, reference through non-POR resets.
// - Power-on and supply monitor resets drive reset pin low until exit.
// - Exit clears program counter and selects internal oscillator.
// - Exit enables watchdog and starts fetch at address 0x0000.
// - Eight request sources each enter reset.
`timescale 1ns/1ps
`default_nettype none
module srst_ctrl #(
    parameter int PORT_W = 28
) (
    input  wire logic                       clk,
    input  wire logic                       rst,
    input  wire logic                       por_req,
    input  wire logic                       reset_pin_n_in,
    input  wire logic                       cmp_req,
    input  wire logic                       sw_req,
    input  wire logic                       smon_req,
    input  wire logic                       wdt_req,
    input  wire logic                       mcd_req,
    input  wire logic                       flash_err_req,
    input  wire logic                       keep_state_en,
    output logic                            reset_pin_n_out,
    output logic                            reset_pin_n_oe,
    output logic                            core_halt,
    output logic                            reg_reset,
    output logic                            por_reset,
    output logic                            port_force,
    output logic [PORT_W-1:0]               port_latch,
    output logic                            port_open_drain,
    output logic                            port_pullup_en,
    output logic                            port_hold,
    output logic                            analog_hold,
    output logic                            irq_disable,
    output logic                            timer_disable,
    output logic                            ram_write_block,
    output logic                            pc_clear,
    output logic                            sysclk_sel_internal,
    output logic                            wdt_enable,
    output logic                            fetch_start,
    output logic [srst_pkg::ADDR_W-1:0]     fetch_addr,
    output logic [srst_pkg::SRC_W-1:0]      reset_cause
);
    localparam logic [srst_pkg::CNT_W-1:0] REL_LOAD =
        srst_pkg::CNT_W'(srst_pkg::RELEASE_CYCLES - 1);
    localparam logic [srst_pkg::CNT_W-1:0] MASK_LOAD =
        srst_pkg::CNT_W'(srst_pkg::PIN_MASK_CYCLES);

    srst_req_if req_bus ();

    logic [srst_pkg::SRC_W-1:0] raw_req;

    // Pin is active low; flip it so every request bit is active high
    always_comb begin
        raw_req                     = '0;
        raw_req[srst_pkg::SRC_POR]   = por_req;
        raw_req[srst_pkg::SRC_PIN]   = ~reset_pin_n_in;
        raw_req[srst_pkg::SRC_CMP]   = cmp_req;
        raw_req[srst_pkg::SRC_SW]    = sw_req;
        raw_req[srst_pkg::SRC_SMON]  = smon_req;
        raw_req[srst_pkg::SRC_WDT]   = wdt_req;
        raw_req[srst_pkg::SRC_MCD]   = mcd_req;
        raw_req[srst_pkg::SRC_FLASH] = flash_err_req;
    end

    srst_sync #(
        .MASK (srst_pkg::SYNC_MASK)
    ) srst_sync_inst (
        .clk (clk),
        .rst (rst),
        .raw (raw_req),
        .out (req_bus.src)
    );

    // Sequencer state
    srst_pkg::srst_state_t             state;
    srst_pkg::srst_state_t             next_state;
    logic [srst_pkg::CNT_W-1:0]        rel_cnt;
    logic [srst_pkg::CNT_W-1:0]        next_rel_cnt;
    logic [srst_pkg::CNT_W-1:0]        mask_cnt;
    logic [srst_pkg::CNT_W-1:0]        next_mask_cnt;
    logic [srst_pkg::SRC_W-1:0]        cause;
    logic [srst_pkg::SRC_W-1:0]        next_cause;
    logic [srst_pkg::SRC_W-1:0]        req_eff;
    logic                              any_req;
    logic                              pin_driven;

    function automatic logic drives_pin(
        input logic [srst_pkg::SRC_W-1:0] c
    );
        drives_pin = c[srst_pkg::SRC_POR] | c[srst_pkg::SRC_SMON];
    endfunction

    // Down-count shared by the release and pin-mask timers; it saturates
    // so an idle counter stays at zero instead of wrapping
    function automatic logic [srst_pkg::CNT_W-1:0] count_down(
        input logic [srst_pkg::CNT_W-1:0] c
    );
        count_down = (c != '0) ? c - 1'b1 : c;
    endfunction

    // Our own low drive echoes back on the pin input; ignore it while
    // driving and until the released level has crossed the synchroniser
    assign pin_driven = (state == srst_pkg::SRST_HOLD ||
                         state == srst_pkg::SRST_RELEASE) && drives_pin(cause);

    always_comb begin
        req_eff = req_bus.req;
        if (pin_driven || mask_cnt != '0) begin
            req_eff[srst_pkg::SRC_PIN] = 1'b0;
        end
        any_req = |req_eff;
    end

    always_comb begin
        next_state    = state;
        next_rel_cnt  = rel_cnt;
        next_cause    = cause;
        next_mask_cnt = count_down(mask_cnt);
        case (state)
            srst_pkg::SRST_RUN: begin
                if (any_req) begin
                    next_state = srst_pkg::SRST_HOLD;
                    next_cause = req_eff;
                end
            end
            srst_pkg::SRST_HOLD: begin
                next_cause = cause | req_eff;
                if (!any_req) begin
                    next_state   = srst_pkg::SRST_RELEASE;
                    next_rel_cnt = REL_LOAD;
                end
            end
            srst_pkg::SRST_RELEASE: begin
                next_cause = cause | req_eff;
                if (any_req) begin
                    next_state = srst_pkg::SRST_HOLD;
                end else if (rel_cnt == '0) begin
                    next_state = srst_pkg::SRST_EXIT;
                    // Mask the echo of our own drive once it is let go
                    if (drives_pin(cause)) begin
                        next_mask_cnt = MASK_LOAD;
                    end
                end else begin
                    next_rel_cnt = count_down(rel_cnt);
                end
            end
            srst_pkg::SRST_EXIT: begin
                // A one-cycle request in the exit cycle would otherwise be
                // lost, so it re-enters hold at once
                if (any_req) begin
                    next_state = srst_pkg::SRST_HOLD;
                    next_cause = req_eff;
                end else begin
                    next_state = srst_pkg::SRST_RUN;
                end
            end
            default: begin
                next_state = srst_pkg::SRST_HOLD;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state    <= srst_pkg::SRST_HOLD;
            rel_cnt  <= '0;
            mask_cnt <= '0;
            cause    <= srst_pkg::CAUSE_RESET;
        end else begin
            state    <= next_state;
            rel_cnt  <= next_rel_cnt;
            mask_cnt <= next_mask_cnt;
            cause    <= next_cause;
        end
    end

    // Output values, all registered so nothing glitches onto the chip
    logic                          in_reset;
    logic                          is_por;
    logic                          keep;
    logic                          next_reset_pin_n_out;
    logic                          next_reset_pin_n_oe;
    logic                          next_core_halt;
    logic                          next_reg_reset;
    logic                          next_por_reset;
    logic                          next_port_force;
    logic                          next_port_hold;
    logic                          next_analog_hold;
    logic                          next_ram_write_block;
    logic                          next_pc_clear;
    logic                          next_sysclk_sel_internal;
    logic                          next_wdt_enable;
    logic                          next_fetch_start;
    logic [srst_pkg::SRC_W-1:0]    next_reset_cause;

    always_comb begin
        in_reset = (next_state == srst_pkg::SRST_HOLD ||
                    next_state == srst_pkg::SRST_RELEASE);
        is_por   = next_cause[srst_pkg::SRC_POR];
        // Hold request only honoured when power was never lost
        keep     = keep_state_en && !is_por;

        next_core_halt       = in_reset || next_state == srst_pkg::SRST_EXIT;
        next_reg_reset       = in_reset;
        next_por_reset       = in_reset && is_por;
        next_port_force      = in_reset && !keep;
        next_port_hold       = in_reset && keep;
        next_analog_hold     = in_reset && keep;
        // RAM contents survive reset; block any write strobe meanwhile
        next_ram_write_block = in_reset;

        next_reset_pin_n_oe  = in_reset && drives_pin(next_cause);
        next_reset_pin_n_out = !next_reset_pin_n_oe;

        next_pc_clear            = next_state == srst_pkg::SRST_EXIT;
        next_sysclk_sel_internal = next_state == srst_pkg::SRST_EXIT;
        next_wdt_enable          = next_state == srst_pkg::SRST_EXIT;
        next_fetch_start         = next_state == srst_pkg::SRST_EXIT;

        next_reset_cause = (next_state == srst_pkg::SRST_EXIT) ?
                           next_cause : reset_cause;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            core_halt           <= 1'b1;
            reg_reset           <= 1'b1;
            por_reset           <= 1'b1;
            port_force          <= 1'b1;
            port_hold           <= 1'b0;
            analog_hold         <= 1'b0;
            ram_write_block     <= 1'b1;
            reset_pin_n_oe      <= 1'b1;
            reset_pin_n_out     <= 1'b0;
            pc_clear            <= 1'b0;
            sysclk_sel_internal <= 1'b0;
            wdt_enable          <= 1'b0;
            fetch_start         <= 1'b0;
            reset_cause         <= srst_pkg::CAUSE_RESET;
        end else begin
            core_halt           <= next_core_halt;
            reg_reset           <= next_reg_reset;
            por_reset           <= next_por_reset;
            port_force          <= next_port_force;
            port_hold           <= next_port_hold;
            analog_hold         <= next_analog_hold;
            ram_write_block     <= next_ram_write_block;
            reset_pin_n_oe      <= next_reset_pin_n_oe;
            reset_pin_n_out     <= next_reset_pin_n_out;
            pc_clear            <= next_pc_clear;
            sysclk_sel_internal <= next_sysclk_sel_internal;
            wdt_enable          <= next_wdt_enable;
            fetch_start         <= next_fetch_start;
            reset_cause         <= next_reset_cause;
        end
    end

    // Port defaults stand during and after reset; they are constants
    // held in flops so the outputs stay registered
    logic [PORT_W-1:0]             next_port_latch;
    logic                          next_port_open_drain;
    logic                          next_port_pullup_en;
    logic                          next_irq_disable;
    logic                          next_timer_disable;
    logic [srst_pkg::ADDR_W-1:0]   next_fetch_addr;

    // Interrupt and timer gates follow the register reset exactly
    always_comb begin
        next_port_latch      = {PORT_W{srst_pkg::PORT_LATCH_RESET}};
        next_port_open_drain = 1'b1;
        next_port_pullup_en  = 1'b1;
        next_irq_disable     = next_reg_reset;
        next_timer_disable   = next_reg_reset;
        next_fetch_addr      = srst_pkg::START_VECTOR;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            port_latch      <= {PORT_W{srst_pkg::PORT_LATCH_RESET}};
            port_open_drain <= 1'b1;
            port_pullup_en  <= 1'b1;
            irq_disable     <= 1'b1;
            timer_disable   <= 1'b1;
            fetch_addr      <= srst_pkg::START_VECTOR;
        end else begin
            port_latch      <= next_port_latch;
            port_open_drain <= next_port_open_drain;
            port_pullup_en  <= next_port_pullup_en;
            irq_disable     <= next_irq_disable;
            timer_disable   <= next_timer_disable;
            fetch_addr      <= next_fetch_addr;
        end
    end
endmodule // srst_ctrl
`default_nettype wire

// ===== srst_props.sv
// Port checks for the system reset controller
`timescale 1ns/1ps
`default_nettype none
module srst_props #(
    parameter int PORT_W = 28
) (
    input wire logic                        clk,
    input wire logic                        rst,
    input wire logic                        por_req,
    input wire logic                        cmp_req,
    input wire logic                        sw_req,
    input wire logic                        smon_req,
    input wire logic                        wdt_req,
    input wire logic                        mcd_req,
    input wire logic                        flash_err_req,
    input wire logic                        reset_pin_n_out,
    input wire logic                        reset_pin_n_oe,
    input wire logic                        core_halt,
    input wire logic                        reg_reset,
    input wire logic                        por_reset,
    input wire logic [PORT_W-1:0]           port_latch,
    input wire logic                        port_open_drain,
    input wire logic                        port_pullup_en,
    input wire logic                        irq_disable,
    input wire logic                        timer_disable,
    input wire logic                        ram_write_block,
    input wire logic                        pc_clear,
    input wire logic                        sysclk_sel_internal,
    input wire logic                        wdt_enable,
    input wire logic                        fetch_start,
    input wire logic [srst_pkg::ADDR_W-1:0] fetch_addr
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // Pin is left out: the pin reads low while the block drives it
    logic       any_req;
    logic [3:0] quiet;
    assign any_req = por_req | cmp_req | sw_req | smon_req | wdt_req
                   | mcd_req | flash_err_req;
    always_ff @(posedge clk) begin
        if (rst || any_req) quiet <= 4'h0;
        else if (quiet != 4'hf) quiet <= quiet + 4'h1;
    end

    a_sync_enters: assert property (
        sw_req || flash_err_req |=> reg_reset && core_halt)
        else $error("same-clock request did not enter reset");
    a_async_enters: assert property (
        $rose(por_req || cmp_req || smon_req || wdt_req || mcd_req)
        |-> ##[1:3] reg_reset) else $error("request did not enter reset");
    a_reset_effects: assert property (
        reg_reset |-> core_halt && irq_disable && timer_disable
        && ram_write_block) else $error("reset state incomplete");
    a_port_default: assert property (
        &port_latch && port_open_drain && port_pullup_en)
        else $error("port defaults wrong");
    a_exit_pulses: assert property (
        $fell(reg_reset) |-> pc_clear && sysclk_sel_internal && wdt_enable
        && fetch_start && core_halt
        && fetch_addr == srst_pkg::START_VECTOR)
        else $error("exit cycle wrong");
    a_exit_once: assert property (
        pc_clear |=> !pc_clear && !fetch_start)
        else $error("exit pulse too long");
    a_hold_release: assert property (
        $fell(reg_reset) |-> quiet >= 4'h8)
        else $error("reset released too early");
    a_pin_driven: assert property (
        reset_pin_n_oe |-> !reset_pin_n_out && core_halt)
        else $error("pin driven outside reset");
    a_smon_pin: assert property (
        $rose(smon_req) |-> ##[1:3] reset_pin_n_oe)
        else $error("pin not driven on supply reset");
    a_por_bits: assert property (
        por_reset |-> reg_reset) else $error("power-on bits out of reset");
endmodule // srst_props

bind srst_ctrl srst_props #(.PORT_W(PORT_W)) srst_props_inst (
    .clk(clk), .rst(rst), .por_req(por_req), .cmp_req(cmp_req),
    .sw_req(sw_req), .smon_req(smon_req), .wdt_req(wdt_req),
    .mcd_req(mcd_req), .flash_err_req(flash_err_req),
    .reset_pin_n_out(reset_pin_n_out), .reset_pin_n_oe(reset_pin_n_oe),
    .core_halt(core_halt), .reg_reset(reg_reset), .por_reset(por_reset),
    .port_latch(port_latch), .port_open_drain(port_open_drain),
    .port_pullup_en(port_pullup_en), .irq_disable(irq_disable),
    .timer_disable(timer_disable), .ram_write_block(ram_write_block),
    .pc_clear(pc_clear), .sysclk_sel_internal(sysclk_sel_internal),
    .wdt_enable(wdt_enable), .fetch_start(fetch_start),
    .fetch_addr(fetch_addr)
);
`default_nettype wire

// ===== srst_src_model.sv
// Reset requesters and the pulled-up reset pin around the controller
`timescale 1ns/1ps
`default_nettype none
module srst_src_model (
    input  wire logic                       clk,
    input  wire logic [srst_pkg::SRC_W-1:0] cmd,
    input  wire logic                       pin_oe,
    output logic      [srst_pkg::SRC_W-1:0] req,
    output logic                            pin_level
);
    // Requesters are level sources; each follows its command one edge on
    initial req = 8'h00;
    always @(posedge clk) begin
        req <= cmd;
    end
    // Pull-up: low while the block drives or a button holds it down
    assign pin_level = !(pin_oe || cmd[srst_pkg::SRC_PIN]);
endmodule // srst_src_model
`default_nettype wire

// ===== system_reset_controller_test.sv
// Self-checking bench for the system reset controller
`timescale 1ns/1ps
`default_nettype none
module system_reset_controller_test;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        keep = 1'b0;
    logic [7:0]  cmd = 8'h00;
    logic [7:0]  req;
    logic        pin, pin_out, pin_oe, halt, rreg, rpor, pforce, pod, ppu;
    logic        phold, ahold, irqd, tmrd, ramb, pcc, clks, wdte, fst;
    logic [27:0] latch;
    logic [15:0] faddr;
    logic [7:0]  cause;
    int          n_fail = 0;
    int          n_compared = 0;

    always #4 clk = ~clk;

    srst_src_model srst_src_model_inst (.clk(clk), .cmd(cmd),
        .pin_oe(pin_oe), .req(req), .pin_level(pin));
    srst_ctrl srst_ctrl_inst (.clk(clk), .rst(rst), .por_req(req[0]),
        .reset_pin_n_in(pin), .cmp_req(req[2]), .sw_req(req[3]),
        .smon_req(req[4]), .wdt_req(req[5]), .mcd_req(req[6]),
        .flash_err_req(req[7]), .keep_state_en(keep),
        .reset_pin_n_out(pin_out), .reset_pin_n_oe(pin_oe),
        .core_halt(halt), .reg_reset(rreg), .por_reset(rpor),
        .port_force(pforce), .port_latch(latch), .port_open_drain(pod),
        .port_pullup_en(ppu), .port_hold(phold), .analog_hold(ahold),
        .irq_disable(irqd), .timer_disable(tmrd), .ram_write_block(ramb),
        .pc_clear(pcc), .sysclk_sel_internal(clks), .wdt_enable(wdte),
        .fetch_start(fst), .fetch_addr(faddr), .reset_cause(cause));

    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("compared %0d mismatched %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic cyc(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic go(logic [7:0] v);
        @(posedge clk);
        cmd <= v;
    endtask

    // Checks the exit cycle; k is how many edges it took
    task automatic wait_exit(output int k);
        k = 0;
        while (pcc !== 1'b1 && k < 60) begin
            cyc(1);
            k++;
        end
        if (k == 60) begin
            check("exit wait", pcc, 1'b1);
            conclude();
        end
        check("exit", {halt, rreg, clks, wdte, fst}, 5'h17);
        check("fetch_addr", faddr, 16'h0000);
        cyc(1);
        check("run", {halt, pcc, pin_oe}, 3'h0);
        check("run pins", {pod, ppu, pin_out, &latch}, 4'hf);
    endtask

    task automatic t_power_up();
        int k;
        check("in rst", {halt, rreg, rpor, pin_oe, latch}, 32'hffffffff);
        check("rst pins", {pod, ppu, pin_out}, 3'h6);
        @(posedge clk);
        rst <= 1'b0;
        wait_exit(k);
        check("por cause", cause, 8'h01);
        $display("power up done");
    endtask

    task automatic t_sources();
        int k;
        for (int i = 0; i < 8; i++) begin
            go(8'h01 << i);
            cyc(5);
            check("entry", {halt, rreg, irqd, tmrd, ramb, pforce}, 6'h3f);
            check("pin oe", pin_oe, i == 0 || i == 4);
            check("por bits", rpor, i == 0);
            cyc(6);
            check("held", rreg, 1'b1);
            go(8'h00);
            wait_exit(k);
            check("exit delay", k >= 8 && k <= 14, 1'b1);
            check("cause", cause, 8'h01 << i);
        end
        $display("sources done");
    endtask

    task automatic t_keep();
        int k;
        @(posedge clk);
        keep <= 1'b1;
        go(8'h08);
        cyc(3);
        check("hold", {phold, ahold, pforce, rpor}, 4'hc);
        go(8'h00);
        wait_exit(k);
        go(8'h01);
        cyc(5);
        check("por no hold", {phold, ahold, pforce}, 3'h1);
        go(8'h00);
        wait_exit(k);
        @(posedge clk);
        keep <= 1'b0;
        $display("keep done");
    endtask

    task automatic t_overlap();
        int k;
        go(8'h28);
        cyc(5);
        go(8'h20);
        cyc(12);
        check("wdt still", {rreg, halt}, 2'h3);
        go(8'h00);
        cyc(6);
        check("in release", {rreg, pcc}, 2'h2);
        go(8'h08);
        go(8'h00);
        wait_exit(k);
        check("restart delay", k >= 8 && k <= 14, 1'b1);
        check("merged cause", cause, 8'h28);
        $display("overlap done");
    endtask

    // Block reset during a watchdog reset acts as a power-on reset
    task automatic t_rerun();
        int k;
        go(8'h20);
        cyc(5);
        @(posedge clk);
        rst <= 1'b1;
        cmd <= 8'h00;
        cyc(2);
        check("rerun", {rpor, pin_oe, cause}, 10'h301);
        @(posedge clk);
        rst <= 1'b0;
        wait_exit(k);
        check("rerun delay", k >= 8 && k <= 14, 1'b1);
        check("rerun cause", cause, 8'h01);
        $display("rerun done");
    endtask

    initial begin
        cyc(15);
        t_power_up();
        t_sources();
        t_keep();
        t_overlap();
        t_rerun();
        conclude();
    end
endmodule // system_reset_controller_test
`default_nettype wire
